//--- rtl/dscp_fifo.sv
module dscp_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] wr_next;
  logic [AW:0] rd_reg;
  logic [AW:0] rd_next;
  logic push;
  logic pop;
  logic valid_reg;
  logic valid_next;
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] data_next;

  // full when pointers differ only in the wrap bit
  // head word and valid are registered so the outputs come from flops;
  // a push into the slot that becomes the head is forwarded past the memory
  always_comb begin
    in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
    push = in_valid && in_ready;
    pop = valid_reg && out_ready;
    wr_next = wr_reg + (AW + 1)'(push);
    rd_next = rd_reg + (AW + 1)'(pop);
    valid_next = wr_next != rd_next;
    data_next = mem[rd_next[AW-1:0]];
    if (push && wr_reg[AW-1:0] == rd_next[AW-1:0]) begin
      data_next = in_data;
    end
  end

  assign out_valid = valid_reg;
  assign out_data = data_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      valid_reg <= valid_next;
      data_reg <= data_next;
    end
  end

  // storage has no reset; a stale slot can load data_reg, but only while out_valid is low
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule : dscp_fifo

//--- rtl/dscp_port.sv
// What this block does
// - shift register works only while select_load_n is low; clock ignored otherwise
// - serial_in sampled on each rising shift clock edge while selected
// - frame is command, four ignored bits, 16-bit data, MSB first
// - data field holds code MSB first, low bits ignored per variant
// - frames of 24 or 32 bits accepted; 32-bit has 8 leading pad bits
// - select_load_n rising ends shifting and executes last 24-bit frame
// - codes 0 write, 1 update, 3 write+update, 4 power down, F nop
// - write loads 16-bit data into input register only
// - update copies input to DAC register and powers up
// - chain_serial_out is last stage, changing on following falling edge
// - chain_serial_out always driven, even while deselected
// - clear low holds both registers at zero in standard variant
// - midscale variant clears registers to midscale code
// - update pin falling while deselected copies input to DAC register
// - update pin falling while selected defers update until select rises
// - update pin low powers up and suppresses power-down commands
// - power-on values are zero, or midscale in midscale variant
// - power-down leaves both registers unchanged, data ignored
// - update pulse ending before select rises powers up but no update
module dscp_port
  import dscp_pkg::*;
#(
  parameter bit MIDSCALE = 1'b0,
  parameter int LOWPAD = dscp_pkg::LOWPAD_16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic select_load_n,
  input wire logic async_update_n,
  input wire logic async_clear_n,
  output logic chain_serial_out,
  output logic [15:0] input_code,
  output logic [15:0] dac_code,
  output logic powered_down,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [19:0] cmd_word,
  output logic cmd_overflow
);
  import dscp_pkg::*;

  logic [3:0] pins_sync;
  logic sck_s;
  logic sdi_s;
  logic sel_n_s;
  logic upd_n_s;
  logic sck_d_reg;
  logic sel_d_reg;
  logic upd_d_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic sdo_reg;
  logic sdo_next;
  logic [15:0] in_reg;
  logic [15:0] in_next;
  logic [15:0] dac_reg;
  logic [15:0] dac_next;
  logic pd_reg;
  logic pd_next;
  logic defer_reg;
  logic defer_next;
  logic ovf_reg;
  logic ovf_next;
  logic clr_m_reg;
  logic clr_reg;
  logic sck_rise;
  logic sck_fall;
  logic sel_rise;
  logic upd_fall;
  logic [3:0] cmd;
  logic [15:0] data;
  logic fifo_in_ready;
  logic [15:0] clear_code;

  // low bits ignored
  // masks the ignored low-order bits of the data field
  function automatic logic [15:0] code_mask(input logic [15:0] d);
    code_mask = d & ~((16'h0001 << LOWPAD) - 16'h0001);
  endfunction : code_mask

  // pins are outside the mclk domain
  dscp_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({shift_clk, serial_in, select_load_n, async_update_n}),
    .sync_out(pins_sync)
  );
  assign sck_s = pins_sync[3];
  assign sdi_s = pins_sync[2];
  assign sel_n_s = pins_sync[1];
  assign upd_n_s = pins_sync[0];

  // clear is level-sensitive; synchronised release keeps it glitch-safe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clr_m_reg <= 1'b1;
      clr_reg <= 1'b1;
    end else begin
      clr_m_reg <= ~async_clear_n;
      clr_reg <= clr_m_reg;
    end
  end

  // edge detect on synchronised pins
  // reset values match the idle pin levels so no false edge follows reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      upd_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_n_s;
      upd_d_reg <= upd_n_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_reg && !sel_n_s;
  assign sck_fall = !sck_s && sck_d_reg && !sel_n_s;
  assign sel_rise = sel_n_s && !sel_d_reg;
  assign upd_fall = !upd_n_s && upd_d_reg;
  assign cmd = shift_reg[CMD_POS +: CMD_W];
  assign data = code_mask(shift_reg[DATA_POS +: DATA_W]);
  assign clear_code = MIDSCALE ? MID_CODE : ZERO_CODE;

  // shift path and chain output
  always_comb begin
    shift_next = shift_reg;
    sdo_next = sdo_reg;
    if (sck_rise) begin
      shift_next = {shift_reg[30:0], sdi_s};
    end
    // last stage out on falling edge
    if (sck_fall) begin
      sdo_next = shift_reg[SHIFT_W-1];
    end
  end

  // command execution and data registers
  always_comb begin
    in_next = in_reg;
    dac_next = dac_reg;
    pd_next = pd_reg;
    defer_next = defer_reg;
    ovf_next = ovf_reg;
    if (upd_fall && sel_n_s == 1'b0) begin
      defer_next = 1'b1;
    end
    if (!upd_n_s) begin
      pd_next = 1'b0;
    end
    if (upd_fall && sel_n_s) begin
      dac_next = in_reg;
    end
    if (sel_rise) begin
      defer_next = 1'b0;
      ovf_next = ovf_reg | !fifo_in_ready;
      case (cmd)
        CMD_WRITE: begin
          in_next = data;
        end
        CMD_UPDATE: begin
          dac_next = in_reg;
          pd_next = 1'b0;
        end
        CMD_WR_UPD: begin
          in_next = data;
          dac_next = data;
          pd_next = 1'b0;
        end
        CMD_PWR_DOWN: begin
          // suppressed while update low; registers kept
          pd_next = upd_n_s;
        end
        default: begin
        end
      endcase
      // pin still low when select rose: deferred update
      if (defer_reg && !upd_n_s) begin
        dac_next = (cmd == CMD_WRITE || cmd == CMD_WR_UPD) ? data : in_reg;
        pd_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= SHIFT_RESET;
      sdo_reg <= 1'b0;
      in_reg <= MIDSCALE ? MID_CODE : ZERO_CODE;
      dac_reg <= MIDSCALE ? MID_CODE : ZERO_CODE;
      pd_reg <= 1'b0;
      defer_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (clr_reg) begin
      shift_reg <= SHIFT_RESET;
      sdo_reg <= 1'b0;
      in_reg <= clear_code;
      dac_reg <= clear_code;
      pd_reg <= pd_reg;
      defer_reg <= 1'b0;
      ovf_reg <= ovf_reg;
    end else begin
      shift_reg <= shift_next;
      sdo_reg <= sdo_next;
      in_reg <= in_next;
      dac_reg <= dac_next;
      pd_reg <= pd_next;
      defer_reg <= defer_next;
      ovf_reg <= ovf_next;
    end
  end

  // executed frames logged; a stalled reader sets the sticky overflow flag
  dscp_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(sel_rise && !clr_reg),
    .in_ready(fifo_in_ready),
    .in_data({cmd, data}),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_word)
  );

  assign chain_serial_out = sdo_reg;
  assign input_code = in_reg;
  assign dac_code = dac_reg;
  assign powered_down = pd_reg;
  assign cmd_overflow = ovf_reg;

  // checks
  wr_keeps_dac_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && cmd == CMD_WRITE && !clr_reg && !defer_reg && !upd_fall) |=> (dac_reg == $past(dac_reg)))
    else $error("write changed dac register");
  wr_loads_in_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && cmd == CMD_WRITE && !clr_reg) |=> (in_reg == $past(data)))
    else $error("write did not load input register");
  upd_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && cmd == CMD_UPDATE && !clr_reg) |=> (dac_reg == $past(in_reg) && !pd_reg))
    else $error("update failed");
  pd_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && cmd == CMD_PWR_DOWN && upd_n_s && !clr_reg && !defer_reg)
    |=> (pd_reg && in_reg == $past(in_reg) && dac_reg == $past(dac_reg)))
    else $error("power down disturbed registers");
  pd_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!upd_n_s && !clr_reg) |=> !pd_reg)
    else $error("powered down while update pin low");
  clr_val_a: assert property (@(posedge mclk) disable iff (!rst_b)
    clr_reg |=> (in_reg == clear_code && dac_reg == clear_code))
    else $error("clear value wrong");
  sck_ignore_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_n_s && !clr_reg) |=> (shift_reg == $past(shift_reg)))
    else $error("shifted while deselected");
  sdo_stage_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sck_fall && !clr_reg) |=> (chain_serial_out == $past(shift_reg[31])))
    else $error("chain output not last stage");
  async_upd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (upd_fall && sel_n_s && !clr_reg && !sel_rise) |=> (dac_reg == $past(in_reg)))
    else $error("async update missed");
  shift_in_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sck_rise && !clr_reg) |=> (shift_reg == {$past(shift_reg[30:0]), $past(sdi_s)}))
    else $error("serial input not shifted in");
  nop_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && cmd == CMD_NOP && upd_n_s && !clr_reg)
    |=> (in_reg == $past(in_reg) && dac_reg == $past(dac_reg) && pd_reg == $past(pd_reg)))
    else $error("no operation changed registers");
  // deferred and pulsed update paths
  defer_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (upd_fall && !sel_n_s && !clr_reg) |=> defer_reg)
    else $error("update while selected not deferred");
  defer_upd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && defer_reg && !upd_n_s && !clr_reg && cmd != CMD_WRITE && cmd != CMD_WR_UPD)
    |=> (dac_reg == $past(in_reg) && !pd_reg))
    else $error("deferred update missed");
  pulse_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sel_rise && defer_reg && upd_n_s && !clr_reg && cmd == CMD_WRITE) |=> (dac_reg == $past(dac_reg) && !pd_reg))
    else $error("ended update pulse changed dac register");
  cv_write_c: cover property (@(posedge mclk) disable iff (!rst_b) sel_rise && cmd == CMD_WRITE);
  cv_wrupd_c: cover property (@(posedge mclk) disable iff (!rst_b) sel_rise && cmd == CMD_WR_UPD);
  cv_pd_c: cover property (@(posedge mclk) disable iff (!rst_b) sel_rise && cmd == CMD_PWR_DOWN);
  cv_defer_c: cover property (@(posedge mclk) disable iff (!rst_b) sel_rise && defer_reg);
  cv_pinupd_c: cover property (@(posedge mclk) disable iff (!rst_b) upd_fall && sel_n_s);
endmodule : dscp_port

//--- rtl/dscp_sync.sv
module dscp_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] sync_reg;
  logic [3:0] sync_next;

  // first stage is read only by the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    // idle pin levels: shift clock parked low, the rest high, so reset makes no edge
    if (!rst_b) begin
      meta_reg <= 4'h7;
      sync_reg <= 4'h7;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : dscp_sync

//--- shared/dscp_pkg.sv
package dscp_pkg;
  // frame geometry
  localparam int SHIFT_W = 32;
  localparam int FRAME_W = 24;
  localparam int CMD_W = 4;
  localparam int DATA_W = 16;
  localparam int CMD_POS = 20;
  localparam int DATA_POS = 0;
  // resolution variants: number of ignored low-order bits
  localparam int LOWPAD_16 = 0;
  localparam int LOWPAD_14 = 2;
  localparam int LOWPAD_12 = 4;
  // register values after reset or clear
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;
  // fifo of executed commands
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 20;
  // command codes
  typedef enum logic [3:0] {
    CMD_WRITE = 4'h0,
    CMD_UPDATE = 4'h1,
    CMD_WR_UPD = 4'h3,
    CMD_PWR_DOWN = 4'h4,
    CMD_NOP = 4'hF
  } dscp_cmd_t;
endpackage : dscp_pkg

//--- testbench/dscp_host_model.sv
module dscp_host_model (
  output logic shift_clk,
  output logic serial_in,
  output logic select_load_n,
  input wire logic chain_serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: deselected, clock parked low
  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b1;
    select_load_n = 1'b1;
  end
  task automatic send(input logic [31:0] w, input int n, output logic [31:0] seen);
    seen = 32'h0;
    select_load_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      // msb first, set in low phase
      serial_in = w[i];
      #80;
      seen = {seen[30:0], chain_serial_out};
      shift_clk = 1'b1;
      #80;
      shift_clk = 1'b0;
    end
    #80;
    // one frame per device, shared select
    select_load_n = 1'b1;
    // released line must not keep the last bit
    serial_in = ~serial_in;
    #80;
  endtask : send
  // clock pulses with select high, which the port must ignore
  task automatic stray(input int n);
    repeat (n) begin
      #80 shift_clk = 1'b1;
      #80 shift_clk = 1'b0;
    end
  endtask : stray
endmodule : dscp_host_model

//--- testbench/test_dscp_port.sv
module test_dscp_port;
  timeunit 1ns;
  timeprecision 1ps;
  import dscp_pkg::*;
  logic mclk, rst_b, shift_clk, serial_in, select_load_n, async_update_n, async_clear_n;
  logic chain_serial_out, powered_down, cmd_valid, cmd_ready, cmd_overflow, pd, stall, valid_s;
  logic [15:0] input_code, dac_code, ic, dc;
  logic [19:0] cmd_word, word_s;
  logic [19:0] expect_q[$];
  logic [31:0] seen, last_w;
  int last_n, failures, samples_checked;
  dscp_cmd_t codes[5] = '{CMD_WRITE, CMD_UPDATE, CMD_WR_UPD, CMD_PWR_DOWN, CMD_NOP};
  dscp_port dscp_port_inst (
    .mclk(mclk), .rst_b(rst_b), .shift_clk(shift_clk), .serial_in(serial_in),
    .select_load_n(select_load_n), .async_update_n(async_update_n), .async_clear_n(async_clear_n),
    .chain_serial_out(chain_serial_out), .input_code(input_code), .dac_code(dac_code),
    .powered_down(powered_down), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_word(cmd_word), .cmd_overflow(cmd_overflow)
  );
  dscp_host_model dscp_host_model_inst (
    .shift_clk(shift_clk), .serial_in(serial_in), .select_load_n(select_load_n),
    .chain_serial_out(chain_serial_out)
  );
  // 50 MHz system clock
  always #10 mclk = ~mclk;
  // consumer stalls at random so the log backs up now and then
  // head word captured while settled, ahead of the edge that takes it
  always @(negedge mclk) begin
    cmd_ready <= stall ? 1'b0 : 1'($urandom);
    valid_s <= cmd_valid;
    word_s <= cmd_word;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // log monitor: oldest note against each accepted word
  always @(posedge mclk) begin
    if (valid_s === 1'b1 && cmd_ready === 1'b1) begin
      check({12'h000, word_s}, expect_q.size() != 0 ? {12'h000, expect_q.pop_front()} : 32'hFFFF_FFFF);
    end
  end
  // one frame, expected registers worked out after select rises
  task automatic frame(input dscp_cmd_t c, input logic [15:0] v, input int n);
    logic [31:0] w;
    w = {8'($urandom), c, 4'($urandom), v};
    expect_q.push_back({c, v});
    dscp_host_model_inst.send(w, n, seen);
    case (c)
      CMD_WRITE: ic = v;
      CMD_UPDATE: begin
        dc = ic;
        pd = 1'b0;
      end
      CMD_WR_UPD: begin
        ic = v;
        dc = v;
        pd = 1'b0;
      end
      CMD_PWR_DOWN: if (async_update_n) pd = 1'b1;
      default: ;
    endcase
    if (!async_update_n) begin
      dc = ic;
      pd = 1'b0;
    end
    repeat (8) @(negedge mclk);
    check(input_code, ic);
    check(dac_code, dc);
    check(powered_down, pd);
    if (n == 32 && last_n == 32) check(seen, last_w);
    last_w = w;
    last_n = n;
  endtask : frame
  // bounded wait for the log to empty
  task automatic drain();
    for (int i = 0; i < 3000 && expect_q.size() != 0; i++) @(negedge mclk);
    check(expect_q.size(), 0);
  endtask : drain
  // hang guard
  initial begin
    #800000;
    failures++;
    tally_and_finish();
  end
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    async_update_n = 1'b1;
    async_clear_n = 1'b1;
    stall = 1'b0;
    cmd_ready = 1'b0;
    pd = 1'b0;
    ic = ZERO_CODE;
    dc = ZERO_CODE;
    last_n = 0;
    failures = 0;
    samples_checked = 0;
    void'($urandom(32'h91C6498B));
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    check(input_code, ZERO_CODE);
    check(dac_code, ZERO_CODE);
    check(powered_down, 1'b0);
    check(cmd_overflow, 1'b0);
    // every code, 24-bit then padded 32-bit frames
    for (int k = 0; k < 10; k++) begin
      if (k == 7) dscp_host_model_inst.stray(5);
      frame(codes[k % 5], 16'($urandom), k < 5 ? 24 : 32);
    end
    // pin update while deselected wakes and updates
    frame(CMD_PWR_DOWN, 16'($urandom), 24);
    frame(CMD_WRITE, 16'($urandom), 24);
    async_update_n = 1'b0;
    repeat (3) @(negedge mclk);
    async_update_n = 1'b1;
    repeat (6) @(negedge mclk);
    check(dac_code, ic);
    check(powered_down, 1'b0);
    dc = ic;
    pd = 1'b0;
    // pin falls mid-frame, still low at select rise
    frame(CMD_WRITE, 16'($urandom), 24);
    fork
      frame(CMD_PWR_DOWN, 16'($urandom), 24);
      #800 async_update_n = 1'b0;
    join
    async_update_n = 1'b1;
    // short pulse inside a frame wakes without updating
    frame(CMD_PWR_DOWN, 16'($urandom), 32);
    fork
      frame(CMD_WRITE, 16'($urandom), 32);
      begin
        #800 async_update_n = 1'b0;
        #80 async_update_n = 1'b1;
        pd = 1'b0;
      end
    join
    async_clear_n = 1'b0;
    repeat (6) @(negedge mclk);
    ic = ZERO_CODE;
    dc = ZERO_CODE;
    check(input_code, ZERO_CODE);
    check(dac_code, ZERO_CODE);
    async_clear_n = 1'b1;
    repeat (4) @(negedge mclk);
    // log fills while stalled, seventeenth frame is lost
    drain();
    stall = 1'b1;
    repeat (17) frame(CMD_NOP, 16'($urandom), 24);
    void'(expect_q.pop_back());
    check(cmd_overflow, 1'b1);
    stall = 1'b0;
    drain();
    repeat (4) @(negedge mclk);
    check(cmd_valid, 1'b0);
    tally_and_finish();
  end
endmodule : test_dscp_port
